// file: core/sar_consts.vh
// Timing and layout constants for the converter's digital core
`ifndef SAR_CONSTS_VH
`define SAR_CONSTS_VH
`define SAR_WIDTH        16
`define SAR_MSB_INIT     16'h8000
`define SAR_CLK_NS       10
`define SAR_BIT_NS       3500
`define SAR_TAIL_NS      40
`define SAR_VALID_NS     20
`define SAR_BIT_CYC      ((`SAR_BIT_NS) / (`SAR_CLK_NS))
`define SAR_TAIL_CYC     (((`SAR_TAIL_NS) + (`SAR_CLK_NS) - 1) / (`SAR_CLK_NS))
`define SAR_CNT_W        9
`endif

// file: core/bit_timer.v
// Bit-period divider for the gated conversion clock
`timescale 1ns/1ps
`default_nettype none
module bit_timer #(
  parameter PERIOD = 350,
  parameter CNT_W  = 9
) (
  // Clock and reset
  input  wire             clk,
  input  wire             srst,
  // Control
  input  wire             restart,
  input  wire             run,
  // Timing
  output wire             tick,
  output wire             hi_nxt,
  output wire [CNT_W-1:0] count
);
  localparam integer     LAST_I = PERIOD - 1;
  localparam integer     HALF_I = PERIOD / 2;
  localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] HALF   = HALF_I[CNT_W-1:0];

  reg  [CNT_W-1:0] cnt_r;
  wire [CNT_W-1:0] cnt_nxt;

  assign tick    = run & (cnt_r == LAST);
  assign cnt_nxt = (restart | tick) ? {CNT_W{1'b0}} : cnt_r + 1'b1;
  // High in the first half of each period, so a bit edge is a rising edge
  assign hi_nxt  = (restart | run) & (cnt_nxt < HALF);
  assign count   = cnt_r;

  always @(posedge clk) begin
    if (srst) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (restart | run) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // bit_timer
`default_nettype wire

// file: core/sar_adc_output_short_cycle.v
// Successive-approximation sequencer with inverted outputs and early stop
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.vh"
// How it works
// - Result pins drive inverted polarity
// - Inverted plain unipolar, inverted offset bipolar
// - Data settled 20 ns before busy falls
// - Result pins change only on conversion clock rise
// - Early-stop input ends conversion after any bit
// - Stop after bit n, busy clears 40 ns later
// - Conversion completes within tabulated maximum times
// - Unipolar codes follow plain inverted binary
// - Bipolar codes follow inverted offset binary
// - Trigger sets busy, bits decided MSB first
// - Idle gated clock held low until trigger
module sar_adc_output_short_cycle #(
  parameter WIDTH  = `SAR_WIDTH,
  parameter BIT_CYC = `SAR_BIT_CYC
) (
  // Clock and reset
  input  wire             clk,
  input  wire             srst,
  // Pins from outside
  input  wire             start,
  input  wire             comp_in,
  input  wire             short_cycle_n,
  input  wire             bipolar,
  // Parallel result, negative true
  output reg  [WIDTH-1:0] data_n,
  // Status and gated clock
  output reg              busy,
  output reg              conv_clk,
  output reg              inverted_offset_code,
  output reg              inverted_plain_code
);
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_ARM  = 2'd1;
  localparam [1:0] S_RUN  = 2'd2;
  localparam [1:0] S_TAIL = 2'd3;
  localparam integer TAIL_I    = `SAR_TAIL_CYC - 1;
  localparam integer LAST_I    = WIDTH - 1;
  localparam [3:0]   TAIL_LAST = TAIL_I[3:0];
  localparam [4:0]   LAST_BIT  = LAST_I[4:0];

  reg  [1:0]       state_r;
  reg  [1:0]       state_nxt;
  reg  [WIDTH-1:0] approximation_register_r;
  reg  [WIDTH-1:0] approximation_register_nxt;
  reg  [4:0]       bit_r;
  reg  [3:0]       since_r;
  reg  [2:0]       start_s_r;
  reg  [2:0]       comp_s_r;
  reg  [2:0]       sc_s_r;
  reg  [2:0]       bip_s_r;
  reg              start_q_r;
  reg              comp_q_r;
  reg              sc_low_q_r;
  reg              bip_q_r;
  reg              last_done_r;
  wire             timer_run;
  wire             tick;
  wire             hi_nxt;
  wire             restart;
  wire             start_q;
  wire             comp_q;
  wire             sc_low_q;
  wire             bip_q;
  wire             decide_end;

  // Three-stage synchronisers; a level counts once stages two and three agree
  always @(posedge clk) begin
    if (srst) begin
      start_s_r <= 3'h0;
      comp_s_r  <= 3'h0;
      sc_s_r    <= 3'h7;
      bip_s_r   <= 3'h0;
    end else begin
      start_s_r <= {start_s_r[1:0], start};
      comp_s_r  <= {comp_s_r[1:0], comp_in};
      sc_s_r    <= {sc_s_r[1:0], short_cycle_n};
      bip_s_r   <= {bip_s_r[1:0], bipolar};
    end
  end

  assign start_q  = (start_s_r[1] == start_s_r[2]) ? start_s_r[2] : start_q_r;
  assign comp_q   = (comp_s_r[1] == comp_s_r[2]) ? comp_s_r[2] : comp_q_r;
  assign sc_low_q = (sc_s_r[1] == sc_s_r[2]) ? ~sc_s_r[2] : sc_low_q_r;
  assign bip_q    = (bip_s_r[1] == bip_s_r[2]) ? bip_s_r[2] : bip_q_r;

  always @(posedge clk) begin
    if (srst) begin
      start_q_r  <= 1'b0;
      comp_q_r   <= 1'b0;
      sc_low_q_r <= 1'b0;
      bip_q_r    <= 1'b0;
    end else begin
      start_q_r  <= start_q;
      comp_q_r   <= comp_q;
      sc_low_q_r <= sc_low_q;
      bip_q_r    <= bip_q;
    end
  end

  // Trailing edge of the trigger initialises the register and starts t0
  assign restart = (state_r == S_ARM) & ~start_q;

  // Timer runs through the tail too, so each bit period stays BIT_CYC long
  assign timer_run = (state_r == S_RUN) | (state_r == S_TAIL);


  bit_timer #(
    .PERIOD (BIT_CYC),
    .CNT_W  (`SAR_CNT_W)
  ) u_timer (
    .clk     (clk),
    .srst    (srst),
    .restart (restart),
    .run     (timer_run),
    .tick    (tick),
    .hi_nxt  (hi_nxt),
    .count   ()
  );

  // The early-stop pin is our own bit n+1 output looped back; it reads
  // low once that bit's trial is set, so it is checked after the settle
  assign decide_end = (since_r == TAIL_LAST) &
                      (last_done_r | sc_low_q);

  always @* begin
    state_nxt = state_r;
    approximation_register_nxt = approximation_register_r;
    case (state_r)
      S_IDLE: begin
        if (start_q) begin
          state_nxt = S_ARM;
        end
      end
      S_ARM: begin
        if (restart) begin
          approximation_register_nxt = `SAR_MSB_INIT;
          state_nxt = S_RUN;
        end
      end
      S_RUN: begin
        if (tick) begin
          // Keep or reject the bit, then set the next trial bit
          approximation_register_nxt[bit_r[3:0]] = comp_q_r;
          if (bit_r != 5'd0) begin
            approximation_register_nxt[bit_r[3:0] - 4'd1] = 1'b1;
          end
          state_nxt = S_TAIL;
        end
      end
      S_TAIL: begin
        if (decide_end) begin
          state_nxt = S_IDLE;
        end else if (since_r == TAIL_LAST) begin
          state_nxt = S_RUN;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state_r <= S_IDLE;
      approximation_register_r <= {WIDTH{1'b0}};
      bit_r   <= LAST_BIT;
      since_r <= 4'h0;
      last_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      approximation_register_r <= approximation_register_nxt;
      if (restart) begin
        bit_r <= LAST_BIT;
      end else if (tick & (bit_r != 5'd0)) begin
        bit_r <= bit_r - 5'd1;
      end else if (tick) begin
        bit_r <= 5'd0;
      end
      if (tick | restart) begin
        since_r <= 4'h0;
      end else if (since_r != 4'hf) begin
        since_r <= since_r + 4'h1;
      end
      // Bit index alone cannot tell the LSB decision from the one before it
      if (restart) begin
        last_done_r <= 1'b0;
      end else if (tick & (bit_r == 5'd0)) begin
        last_done_r <= 1'b1;
      end
    end
  end

  // Tail state keeps the clock phase running while the stop is judged
  // Outputs; data moves only on the edge where the gated clock rises
  always @(posedge clk) begin
    if (srst) begin
      data_n   <= {WIDTH{1'b1}};
      busy     <= 1'b0;
      conv_clk <= 1'b0;
      inverted_offset_code <= 1'b0;
      inverted_plain_code  <= 1'b1;
    end else begin
      if (restart | tick) begin
        data_n <= ~approximation_register_nxt;
      end
      // Busy falls 40 ns after the last decision, data already 40 ns old
      busy <= (state_nxt != S_IDLE);
      conv_clk <= (state_nxt == S_RUN | state_nxt == S_TAIL) &
                  hi_nxt;
      // Same digital code; the analog scaling supplies the offset
      inverted_offset_code <= bip_q;
      inverted_plain_code  <= ~bip_q;
    end
  end
endmodule // sar_adc_output_short_cycle
`default_nettype wire

// file: sim/sar_props.sv
// Port checker for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_props #(
  parameter WIDTH   = 16,
  parameter BIT_CYC = 10
) (
  // Clock and reset
  input wire logic             clk,
  input wire logic             srst,
  // Pins in
  input wire logic             start,
  input wire logic             comp_in,
  input wire logic             short_cycle_n,
  input wire logic             bipolar,
  // Pins out
  input wire logic [WIDTH-1:0] data_n,
  input wire logic             busy,
  input wire logic             conv_clk,
  input wire logic             inverted_offset_code,
  input wire logic             inverted_plain_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic armed_r;
  // Set from busy rising until the first gated clock rise
  always @(posedge clk) begin
    if (srst) armed_r <= 1'b0;
    else if ($rose(busy)) armed_r <= 1'b1;
    else if (conv_clk) armed_r <= 1'b0;
  end
  a_data_on_clk: assert property (!$stable(data_n) |-> $rose(conv_clk))
    else $error("result moved without a clock rise");
  a_valid_before_fall: assert property ($fell(busy) |->
    $past(data_n) == data_n && $past(data_n, 2) == data_n)
    else $error("result not settled before busy fell");
  a_tail_four_cycles: assert property ($fell(busy) |->
    $past(conv_clk, 4) && !$past(conv_clk, 5))
    else $error("busy fell off the decision edge plus four");
  a_idle_clk_low: assert property (!busy |-> !conv_clk)
    else $error("gated clock high while idle");
  a_hold_when_idle: assert property (!busy && !$past(busy) |-> $stable(data_n))
    else $error("result changed while idle");
  a_start_sets_busy: assert property ($rose(start) && !busy |-> ##[2:6] busy)
    else $error("start did not raise busy");
  a_first_trial: assert property (busy && armed_r && $fell(start) |->
    ##[3:6] ($rose(conv_clk) && data_n == 16'h7fff))
    else $error("first trial code missing");
  a_bit_spacing: assert property ($rose(conv_clk) |=> (!$rose(conv_clk))[*8])
    else $error("decision edges too close");
  a_range_code: assert property ($stable(bipolar)[*6] |->
    inverted_offset_code == bipolar && inverted_plain_code != bipolar)
    else $error("code flags disagree with range");
  c_short: cover property ($fell(busy) && !short_cycle_n);
  c_full: cover property ($fell(busy) && short_cycle_n);
  c_retrig: cover property (busy && $rose(start));
endmodule // sar_props
bind sar_adc_output_short_cycle sar_props #(.WIDTH(WIDTH), .BIT_CYC(BIT_CYC))
  sar_props_i (.clk(clk), .srst(srst), .start(start), .comp_in(comp_in),
  .short_cycle_n(short_cycle_n), .bipolar(bipolar), .data_n(data_n),
  .busy(busy), .conv_clk(conv_clk), .inverted_plain_code(inverted_plain_code),
  .inverted_offset_code(inverted_offset_code));
`default_nettype wire

// file: sim/host_model.sv
// Far-side host: comparator, early-stop loopback, result capture
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and status
  input wire logic        clk,
  input wire logic        busy,
  input wire logic [15:0] data_n,
  // Analog stand-in
  input wire logic [15:0] target,
  input wire logic [4:0]  res_bits,
  // To converter and bench
  output logic            comp_in,
  output logic            short_cycle_n,
  output logic [15:0]     captured,
  output logic [15:0]     twos_n
);
  // Keep trial while it does not exceed the input
  assign comp_in = (~data_n) <= target;
  // Loopback from pin of bit n+1; 15-n equals ~n on four bits
  assign short_cycle_n = res_bits[4] ? 1'b1 : data_n[~res_bits[3:0]];
  always @(negedge busy) begin
    captured = ~data_n;
    twos_n = data_n ^ 16'h8000;
  end
endmodule // host_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((e) !== (a)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
module tb_top;
  logic        clk, srst, start, bipolar, comp_in, short_cycle_n;
  logic        busy, conv_clk, offs_code, plain_code;
  logic [15:0] data_n, target, captured, twos_n;
  logic [4:0]  res_bits;
  int          fails, checked, cyc, dur;
  initial begin clk = 0; forever #5 clk = ~clk; end
  sar_adc_output_short_cycle #(.WIDTH(16), .BIT_CYC(10))
    sar_adc_output_short_cycle_i (.clk(clk), .srst(srst), .start(start),
    .comp_in(comp_in), .short_cycle_n(short_cycle_n), .bipolar(bipolar),
    .data_n(data_n), .busy(busy), .conv_clk(conv_clk),
    .inverted_offset_code(offs_code), .inverted_plain_code(plain_code));
  host_model host_model_i (.clk(clk), .busy(busy), .data_n(data_n),
    .target(target), .res_bits(res_bits), .comp_in(comp_in),
    .short_cycle_n(short_cycle_n), .captured(captured), .twos_n(twos_n));
  task close_out;
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin fails++; close_out(); end
  end
  function automatic logic [15:0] expect_code(int n, logic [15:0] tg);
    return (tg & ~(16'hffff >> n)) | ((n < 16) ? (16'h8000 >> n) : 16'h0000);
  endfunction
  task automatic convert(int n, logic [15:0] tg);
    res_bits = 5'(n); target = tg; dur = 0; start = 1'b1;
    repeat (8) @(posedge clk);
    #1 start = 1'b0;
    while (busy !== 1'b0 && dur < 400) begin @(posedge clk); #1 dur++; end
    `CHK("done", 1'b0, busy)
  endtask
  task t_idle_state;
    `CHK("conv_clk", 1'b0, conv_clk)
    `CHK("plain", 1'b1, plain_code)
    bipolar = 1'b1; repeat (6) @(posedge clk); #1;
    `CHK("offset", 1'b1, offs_code)
    `CHK("plain", 1'b0, plain_code)
  endtask
  task automatic t_resolutions;
    int tbl[7] = '{16, 15, 14, 13, 12, 10, 8};
    foreach (tbl[i]) begin
      convert(tbl[i], 16'hb6d3);
      `CHK("result", expect_code(tbl[i], 16'hb6d3), captured)
      `CHK("pins", ~expect_code(tbl[i], 16'hb6d3), data_n)
      `CHK("length", 1'b1, dur >= 10*tbl[i]+5 && dur <= 10*tbl[i]+11)
    end
  endtask
  task automatic t_calib;
    logic [15:0] tg[3] = '{16'h0004, 16'hfff8, 16'h8000};
    logic [13:0] ex[3] = '{14'h3ffe, 14'h0001, 14'h1fff};
    for (int b = 0; b < 2; b++) begin
      bipolar = b[0]; repeat (6) @(posedge clk); #1;
      foreach (tg[i]) begin
        convert(14, tg[i]);
        `CHK("code14", ex[i], data_n[15:2])
        if (b == 1)
          `CHK("twos", ~expect_code(14, tg[i]) ^ 16'h8000, twos_n)
      end
    end
  endtask
  task t_retrigger;
    fork
      convert(16, 16'h5a5a);
      begin repeat (60) @(posedge clk); #1 start = 1'b1;
        repeat (4) @(posedge clk); #1 start = 1'b0; end
    join
    `CHK("length", 1'b1, dur >= 165 && dur <= 171)
    repeat (20) @(posedge clk); #1;
    `CHK("busy", 1'b0, busy)
    `CHK("hold", ~expect_code(16, 16'h5a5a), data_n)
  endtask
  initial begin
    srst = 1; start = 0; bipolar = 0; res_bits = 16; target = 0;
    fails = 0; checked = 0; cyc = 0; dur = 0;
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    t_idle_state;
    t_resolutions;
    t_calib;
    t_retrigger;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
